// File: bench/serial_mem_hold_and_map_test.sv
/*
 * Self-checking bench for the serial memory hold and map link.
 * Assumes smh_link as top and the smh_host model on its pins.
 */
`timescale 1ns/1ps
module serial_mem_hold_and_map_test;
    import smh_pkg::*;
    logic core_clk, rst_n, tx_en, cyc_start, cyc_done, ce, rx_valid;
    logic cs_n, sclk, hold_n, sin, so, so_oe, so_wire, hold_act;
    logic addr_valid, busy;
    logic [7:0] rx_byte, merged, so_cap, old_byte, tx_byte;
    logic [23:0] addr, e_base, e_last;
    logic [6:0] sector;
    logic [2:0] region;
    logic [17:0] page;
    logic [5:0] offset;
    smh_mode_t mode;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_rx = 0;
    assign so_wire = so_oe ? so : 1'bz;
    smh_link u_smh_link (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(ce),
        .cs_n_i(cs_n), .sclk_i(sclk), .hold_n_i(hold_n),
        .serial_in_line_i(sin), .tx_en_i(tx_en), .tx_byte_i(tx_byte),
        .mode_i(mode), .old_byte_i(old_byte), .cycle_start_i(cyc_start),
        .cycle_done_i(cyc_done), .serial_out_line_o(so),
        .serial_out_line_oe_o(so_oe), .hold_active_o(hold_act),
        .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .addr_o(addr),
        .addr_valid_o(addr_valid), .sector_o(sector), .region_o(region),
        .page_o(page), .offset_o(offset), .merged_o(merged),
        .erase_base_o(e_base), .erase_last_o(e_last), .cycle_busy_o(busy)
    );
    smh_host u_smh_host (
        .core_clk_i(core_clk), .serial_out_line_i(so_wire), .cs_n_o(cs_n),
        .sclk_o(sclk), .hold_n_o(hold_n), .serial_in_line_o(sin),
        .so_cap_o(so_cap)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Whole run needs about 1700 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            $display("[FAIL] %0t timeout", $time);
            conclude();
        end
    end
    // Counts received-byte pulses so stray or missing bytes show up
    always @(posedge core_clk) begin
        if (rx_valid === 1'b1) begin
            n_rx <= n_rx + 1;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s saw %0h want %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic pulse(input logic start);
        cyc_start = start;
        cyc_done = !start;
        tick(1);
        cyc_start = 1'b0;
        cyc_done = 1'b0;
        tick(2);
    endtask : pulse
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////
    // Boundary addresses, one per mode so every mode is exercised
    task automatic addr_map();
        logic [23:0] tbl [4] = '{24'h000000, 24'h3FFFC1, 24'hFFFFFF,
                                 24'hA5F0BF};
        logic [23:0] a, sec, base;
        logic [7:0] d, cap, exp_m;
        logic [23:0] elast;
        int n0;
        for (int i = 0; i < 4; i++) begin
            a = tbl[i];
            d = 8'h3C ^ a[7:0];
            mode = smh_mode_t'(i[1:0]);
            tx_byte = 8'hC3 ^ a[15:8];
            old_byte = 8'h5A ^ a[23:16];
            n0 = n_rx;
            u_smh_host.pins(1'b0, 1'b1);
            u_smh_host.send_byte(8'h02);
            u_smh_host.send_byte(a[23:16]);
            cap = so_cap;
            u_smh_host.send_byte(a[15:8]);
            u_smh_host.send_byte(a[7:0]);
            u_smh_host.send_byte(d);
            tick(8);
            sec = a / 24'h020000;
            base = (mode == SMH_ERASE_ARRAY) ? 24'h000000 : sec * 24'h020000;
            exp_m = (mode == SMH_PROGRAM) ? (old_byte & d) :
                    (mode == SMH_WRITE) ? d : 8'hFF;
            elast = (mode == SMH_ERASE_ARRAY) ? 24'hFFFFFF
                : base + 24'h01FFFF;
            check(cap, tx_byte, "tx"); // out msb first
            check(addr, a, "addr"); // in msb first
            check(addr_valid, 1'b1, "aval"); // decode
            check(rx_byte, d, "rx"); // data
            check(n_rx - n0, 5, "rx pulses"); // five bytes
            check(sector, sec, "sector"); // sector
            check(region, sec / 24'h000010, "region");
            check(page, a / 24'h000040, "page"); // page
            check(offset, a % 24'h000040, "offset");
            check(merged, exp_m, "merge"); // cell
            if (mode inside {SMH_ERASE_SECTOR, SMH_ERASE_ARRAY}) begin
                check(e_base, base, "ebase");
                check(e_last, elast, "elast"); // span
            end
            u_smh_host.pins(1'b1, 1'b1);
            tick(6);
            check(addr_valid, 1'b0, "aval off"); // cleared
        end
    endtask : addr_map
    // Pause mid-byte, both clock phases at entry and exit, then resume
    task automatic hold_resume();
        logic [7:0] pat = 8'hB6;
        int n0;
        u_smh_host.pins(1'b0, 1'b1);
        u_smh_host.send_byte(8'h02);
        for (int i = 7; i > 4; i--) u_smh_host.send_bit(pat[i]);
        n0 = n_rx;
        check(so_oe, 1'b1, "oe"); // driving
        u_smh_host.pins(1'b0, 1'b0); // select kept
        tick(5);
        check(hold_act, 1'b1, "hold in"); // clock low
        check(so_oe, 1'b0, "oe off"); // floats
        u_smh_host.send_bit(1'b0);
        u_smh_host.send_bit(1'b1);
        u_smh_host.clk_to(1'b1);
        u_smh_host.pins(1'b0, 1'b1);
        tick(8);
        check(hold_act, 1'b1, "hold kept"); // clock high
        u_smh_host.clk_to(1'b0);
        tick(6);
        check(hold_act, 1'b0, "hold out"); // clock low
        tick(4);
        // This rise is taken as bit 4; the data line still holds a one
        u_smh_host.clk_to(1'b1);
        tick(2);
        u_smh_host.pins(1'b0, 1'b0);
        tick(8);
        check(hold_act, 1'b0, "hold wait"); // clock high
        u_smh_host.clk_to(1'b0);
        tick(6);
        check(hold_act, 1'b1, "hold late"); // next low
        u_smh_host.pins(1'b0, 1'b1);
        tick(6);
        for (int i = 3; i >= 0; i--) u_smh_host.send_bit(pat[i]);
        tick(8);
        check(rx_byte, 8'hB6, "resume"); // kept
        check(n_rx - n0, 1, "one byte"); // no stray bits
        u_smh_host.pins(1'b1, 1'b1);
        tick(6);
    endtask : hold_resume
    // Deselect in hold drops the partial byte; internal cycle runs on
    task automatic hold_deselect();
        int n0;
        pulse(1'b1);
        check(busy, 1'b1, "busy"); // cycle runs
        ce = 1'b0;
        pulse(1'b0);
        check(busy, 1'b1, "frozen"); // enable low
        ce = 1'b1;
        u_smh_host.pins(1'b1, 1'b0);
        tick(6);
        check(hold_act, 1'b0, "no hold"); // needs select
        u_smh_host.pins(1'b1, 1'b1);
        u_smh_host.pins(1'b0, 1'b1);
        for (int i = 0; i < 3; i++) u_smh_host.send_bit(1'b1);
        u_smh_host.pins(1'b0, 1'b0);
        tick(5);
        check(hold_act, 1'b1, "hold"); // entered
        u_smh_host.pins(1'b1, 1'b0);
        tick(6);
        check(hold_act, 1'b0, "reset"); // interface reset
        check(busy, 1'b1, "busy kept"); // not aborted
        u_smh_host.pins(1'b1, 1'b1); // release first
        tx_en = 1'b0;
        n0 = n_rx;
        u_smh_host.pins(1'b0, 1'b1);
        u_smh_host.send_byte(8'h4D);
        tick(8);
        check(so_oe, 1'b0, "oe unasked"); // not driving
        check(rx_byte, 8'h4D, "fresh"); // partial dropped
        check(n_rx - n0, 1, "one pulse"); // fresh byte
        tx_en = 1'b1;
        u_smh_host.pins(1'b1, 1'b1);
        pulse(1'b0);
        check(busy, 1'b0, "done"); // completes
    endtask : hold_deselect
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        tx_byte = 8'hC3;
        tx_en = 1'b1;
        cyc_start = 1'b0;
        cyc_done = 1'b0;
        mode = SMH_PROGRAM;
        old_byte = 8'h5A;
        tick(2);
        rst_n = 1'b1;
        tick(8);
        addr_map();
        hold_resume();
        hold_deselect();
        conclude();
    end
endmodule : serial_mem_hold_and_map_test

// File: bench/smh_host.sv
/*
 * Host model for the serial link: select, clock, hold and serial input.
 * Assumes the bench calls its tasks and feeds it the resolved data out.
 */
`timescale 1ns/1ps
module smh_host (
    input wire logic core_clk_i,
    input wire logic serial_out_line_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic hold_n_o,
    output logic serial_in_line_o,
    output logic [7:0] so_cap_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        hold_n_o = 1'b1;
        serial_in_line_o = 1'b0;
        so_cap_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick
    // Callers release hold before select
    task automatic pins(input logic cs, input logic hold);
        tick(1);
        // Released data flips so a stale level never passes for a bit
        if (cs && !cs_n_o) serial_in_line_o = ~serial_in_line_o;
        cs_n_o = cs; // select first
        hold_n_o = hold;
    endtask : pins
    task automatic clk_to(input logic v);
        tick(1);
        sclk_o = v;
    endtask : clk_to
    // Data changes with clock low, taken on the rise; clock idles low
    task automatic send_bit(input logic b);
        serial_in_line_o = b;
        tick(4);
        sclk_o = 1'b1;
        tick(4);
        so_cap_o = {so_cap_o[6:0], serial_out_line_i};
        sclk_o = 1'b0;
    endtask : send_bit
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]); // msb first
        end
    endtask : send_byte
endmodule : smh_host

// File: verilog/smh_link.sv
/*
 * Serial link front end with hold handling, byte shifting and address
 * capture, plus the array map. Assumes chip select, serial clock, hold
 * and serial input come from pins; the internal cycle flags come from
 * core logic on core_clk_i.
 */
`timescale 1ns/1ps
// How it works
// - Hold low pauses the transfer, keeping bit and byte position.
// - Hold never stops a running status write, program or erase.
// - Hold is entered only while chip select is low.
// - Hold starts at hold falling with clock low, else next clock low.
// - Hold ends at hold rising with clock low, else next clock low.
// - In hold the output floats; input data and clock are ignored.
// - Chip select high during hold resets the interface logic.
// - 128 sectors of 0x20000 bytes, sector n at n times 0x20000.
// - 262,144 pages of 64 bytes each.
// - 8 super page regions of 16 sectors, region 0 lowest.
// - Program clears bits only; bit-alterable write sets either way.
// - Erase covers a sector or the array and sets bits to one.
// - Opcode, address and data move most significant bit first.
module smh_link (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic hold_n_i,
    input wire logic serial_in_line_i,
    input wire logic tx_en_i,
    input wire logic [smh_pkg::BYTE_W-1:0] tx_byte_i,
    input wire smh_pkg::smh_mode_t mode_i,
    input wire logic [smh_pkg::BYTE_W-1:0] old_byte_i,
    input wire logic cycle_start_i,
    input wire logic cycle_done_i,
    output logic serial_out_line_o,
    output logic serial_out_line_oe_o,
    output logic hold_active_o,
    output logic [smh_pkg::BYTE_W-1:0] rx_byte_o,
    output logic rx_valid_o,
    output logic [smh_pkg::ADDR_W-1:0] addr_o,
    output logic addr_valid_o,
    output logic [smh_pkg::SECTOR_W-1:0] sector_o,
    output logic [smh_pkg::REGION_W-1:0] region_o,
    output logic [smh_pkg::PAGE_W-1:0] page_o,
    output logic [smh_pkg::PAGE_LSB-1:0] offset_o,
    output logic [smh_pkg::BYTE_W-1:0] merged_o,
    output logic [smh_pkg::ADDR_W-1:0] erase_base_o,
    output logic [smh_pkg::ADDR_W-1:0] erase_last_o,
    output logic cycle_busy_o
);
    import smh_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic [1:0] rst_pipe;
    logic rst_n;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic sclk_d;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Chip select and hold idle high so the reset value is deselected
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 4'hB;
            pin_s2 <= 4'hB;
            sclk_d <= 1'b0;
        end else if (ce_i) begin
            pin_s1 <= {cs_n_i, sclk_i, hold_n_i, serial_in_line_i};
            pin_s2 <= pin_s1;
            sclk_d <= pin_s2[2];
        end
    end

    wire cs_low = ~pin_s2[3];
    wire sclk_s = pin_s2[2];
    wire hold_low = ~pin_s2[1];
    wire si_s = pin_s2[0];
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;

    ////////////////////////////////////////////////////////////////////////
    // Link state: hold changes only while the clock is low

    smh_link_t state;
    smh_link_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            SMH_IDLE: begin
                if (cs_low) begin
                    next_state = SMH_ACTIVE;
                end
            end
            SMH_ACTIVE: begin
                if (!cs_low) begin
                    next_state = SMH_IDLE;
                end else if (hold_low && !sclk_s) begin
                    next_state = SMH_HOLD;
                end
            end
            SMH_HOLD: begin
                if (!cs_low) begin
                    next_state = SMH_IDLE;
                end else if (!hold_low && !sclk_s) begin
                    next_state = SMH_ACTIVE;
                end
            end
            default: begin
                next_state = SMH_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= SMH_IDLE;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift path; edges count only in the active state

    wire live = (state == SMH_ACTIVE);
    wire take_bit = live && sclk_rise;
    wire drive_bit = live && sclk_fall;

    logic [2:0] bit_pos;
    logic [1:0] byte_pos;
    logic [BYTE_W-1:0] rx_shift;
    logic [BYTE_W-1:0] tx_shift;
    logic load_pend;

    wire [BYTE_W-1:0] next_rx = {rx_shift[BYTE_W-2:0], si_s};
    wire byte_done = take_bit && (bit_pos == LAST_BIT);
    // Saturated byte count cannot tell the last address byte from data,
    // so the valid flag closes the address window
    wire addr_byte = byte_done && (byte_pos != 2'h0) && !addr_valid_o;

    // Deselect clears position; hold leaves it alone
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bit_pos <= 3'h0;
            byte_pos <= 2'h0;
            rx_shift <= 8'h00;
        end else if (ce_i) begin
            if (state == SMH_IDLE) begin
                bit_pos <= 3'h0;
                byte_pos <= 2'h0;
            end else if (take_bit) begin
                bit_pos <= bit_pos + 3'h1;
                rx_shift <= next_rx;
                if (byte_done && byte_pos != ADDR_DONE) begin
                    byte_pos <= byte_pos + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift <= 8'h00;
            load_pend <= 1'b0;
        end else if (ce_i) begin
            if (state == SMH_IDLE) begin
                tx_shift <= tx_byte_i;
                load_pend <= 1'b0;
            end else if (byte_done) begin
                load_pend <= 1'b1;
            end else if (drive_bit) begin
                load_pend <= 1'b0;
                tx_shift <= load_pend ? tx_byte_i
                    : {tx_shift[BYTE_W-2:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Array map

    smh_map_if map_if ();
    logic [ADDR_W-1:0] addr_acc;

    assign map_if.addr = addr_acc;
    assign map_if.mode = mode_i;
    assign map_if.old_byte = old_byte_i;
    assign map_if.new_byte = rx_byte_o;

    smh_map u_map (
        .m (map_if)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs

    wire next_oe = live && tx_en_i;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_line_o <= 1'b0;
            serial_out_line_oe_o <= 1'b0;
            hold_active_o <= 1'b0;
            rx_byte_o <= 8'h00;
            rx_valid_o <= 1'b0;
            addr_acc <= '0;
            addr_valid_o <= 1'b0;
        end else if (ce_i) begin
            serial_out_line_o <= tx_shift[BYTE_W-1];
            serial_out_line_oe_o <= next_oe;
            hold_active_o <= (next_state == SMH_HOLD);
            rx_valid_o <= byte_done;
            if (byte_done) begin
                rx_byte_o <= next_rx;
            end
            if (state == SMH_IDLE) begin
                addr_valid_o <= 1'b0;
            end else if (addr_byte) begin
                addr_acc <= {addr_acc[ADDR_W-BYTE_W-1:0], next_rx};
                addr_valid_o <= (byte_pos == ADDR_DONE);
            end
        end
    end
    assign addr_o = addr_acc;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sector_o <= '0;
            region_o <= '0;
            page_o <= '0;
            offset_o <= '0;
            merged_o <= 8'h00;
            erase_base_o <= '0;
            erase_last_o <= '0;
        end else if (ce_i) begin
            sector_o <= map_if.sector;
            region_o <= map_if.region;
            page_o <= map_if.page;
            offset_o <= map_if.offset;
            merged_o <= map_if.result;
            erase_base_o <= map_if.erase_base;
            erase_last_o <= map_if.erase_last;
        end
    end

    // Internal cycle runs on its own; link state never touches it
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cycle_busy_o <= 1'b0;
        end else if (ce_i) begin
            if (cycle_start_i) begin
                cycle_busy_o <= 1'b1;
            end else if (cycle_done_i) begin
                cycle_busy_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n || !ce_i);

    sequence s_hold_req;
        live && cs_low && hold_low && !sclk_s;
    endsequence

    sequence s_in_hold;
        state == SMH_HOLD;
    endsequence

    a_hold_entry_now: assert property (
        s_hold_req |=> s_in_hold ##0 hold_active_o
    ) else $error("hold not entered with clock low");

    a_hold_wait_low: assert property (
        (live && hold_low && sclk_s && cs_low) |=> (state != SMH_HOLD)
    ) else $error("hold entered while clock high");

    a_hold_exit_now: assert property (
        (s_in_hold ##0 (cs_low && !hold_low && !sclk_s)) |=> live
    ) else $error("hold not left at rising hold with clock low");

    a_hold_keeps_pos: assert property (
        s_in_hold |=> ($stable(bit_pos) && $stable(byte_pos)
            && $stable(rx_shift)) || state == SMH_IDLE
    ) else $error("position moved during hold");

    a_hold_needs_cs: assert property (
        s_in_hold |-> $past(cs_low)
    ) else $error("hold without chip select");

    a_hold_float: assert property (
        s_in_hold ##1 s_in_hold |-> !serial_out_line_oe_o
    ) else $error("output driven in hold");

    a_deselect_reset: assert property (
        (s_in_hold ##0 !cs_low) |=> state == SMH_IDLE ##1 bit_pos == 3'h0
    ) else $error("deselect in hold did not reset");

    a_cycle_survives: assert property (
        (cycle_busy_o && !cycle_done_i) |=> cycle_busy_o
    ) else $error("internal cycle dropped");

    a_map_fields: assert property (
        sector_o[SECTOR_W-1 -: REGION_W] == region_o
            && page_o[PAGE_W-1 -: SECTOR_W] == $past(map_if.sector)
    ) else $error("address fields disagree");

    a_msb_first: assert property (
        byte_done |=> rx_byte_o[0] == $past(si_s)
            && rx_byte_o[7] == $past(rx_shift[6])
    ) else $error("byte not assembled msb first");

    a_program_clears: assert property (
        mode_i == SMH_PROGRAM |=> (merged_o & ~$past(old_byte_i)) == 8'h00
    ) else $error("program set a bit");
endmodule : smh_link

// File: verilog/smh_map.sv
/*
 * Array map: splits a byte address into region, sector, page and offset,
 * and forms the byte that a program, write or erase leaves in a cell.
 * Assumes the requester registers whatever it needs from the results.
 */
`timescale 1ns/1ps
module smh_map (
    smh_map_if.mapper m
);
    import smh_pkg::*;

    wire is_erase = (m.mode == SMH_ERASE_SECTOR)
        || (m.mode == SMH_ERASE_ARRAY);
    wire [BYTE_W-1:0] programmed = m.old_byte & m.new_byte;
    wire [ADDR_W-1:0] sector_base = {m.sector, {SECTOR_LSB{1'b0}}};

    assign m.region = m.addr[ADDR_W-1:REGION_LSB];
    assign m.sector = m.addr[ADDR_W-1:SECTOR_LSB];
    assign m.page = m.addr[ADDR_W-1:PAGE_LSB];
    assign m.offset = m.addr[PAGE_LSB-1:0];

    // Program can only clear bits; write replaces them outright
    assign m.result = is_erase ? ERASED_BYTE
        : (m.mode == SMH_WRITE) ? m.new_byte
        : programmed;

    // Erase always covers a whole sector or the whole array
    assign m.erase_base = (m.mode == SMH_ERASE_ARRAY) ? '0
        : sector_base;
    assign m.erase_last = (m.mode == SMH_ERASE_ARRAY) ? '1
        : sector_base + (SECTOR_BYTES - 24'h000001);
endmodule : smh_map

// File: verilog/smh_map_if.sv
/*
 * Carrier between the link front end and the array map.
 * Assumes both ends sit in one clock domain; paths are combinational.
 */
`timescale 1ns/1ps
interface smh_map_if;
    import smh_pkg::*;
    logic [ADDR_W-1:0] addr;
    smh_mode_t mode;
    logic [BYTE_W-1:0] old_byte;
    logic [BYTE_W-1:0] new_byte;
    logic [BYTE_W-1:0] result;
    logic [SECTOR_W-1:0] sector;
    logic [REGION_W-1:0] region;
    logic [PAGE_W-1:0] page;
    logic [PAGE_LSB-1:0] offset;
    logic [ADDR_W-1:0] erase_base;
    logic [ADDR_W-1:0] erase_last;

    modport requester (
        output addr, mode, old_byte, new_byte,
        input result, sector, region, page, offset, erase_base, erase_last
    );
    modport mapper (
        input addr, mode, old_byte, new_byte,
        output result, sector, region, page, offset, erase_base, erase_last
    );
endinterface : smh_map_if

// File: verilog/smh_pkg.sv
/*
 * Shared constants and types for the serial memory hold and map block.
 * Assumes a 24-bit byte address and a byte-wide serial shift path.
 */
package smh_pkg;
    localparam int ADDR_W = 24;
    localparam int BYTE_W = 8;
    localparam int SECTOR_COUNT = 128;
    localparam logic [23:0] SECTOR_BYTES = 24'h020000;
    localparam int REGION_COUNT = 8;
    localparam int SECTORS_PER_REGION = 16;
    localparam int PAGE_COUNT = 262144;
    localparam int PAGE_BYTES = 64;
    localparam int SECTOR_LSB = 17;
    localparam int REGION_LSB = 21;
    localparam int PAGE_LSB = 6;
    localparam int SECTOR_W = ADDR_W - SECTOR_LSB;
    localparam int REGION_W = ADDR_W - REGION_LSB;
    localparam int PAGE_W = ADDR_W - PAGE_LSB;
    localparam int ADDR_BYTES = 3;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] ADDR_DONE = 2'h3;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        SMH_PROGRAM,
        SMH_WRITE,
        SMH_ERASE_SECTOR,
        SMH_ERASE_ARRAY
    } smh_mode_t;

    typedef enum logic [1:0] {
        SMH_IDLE,
        SMH_ACTIVE,
        SMH_HOLD
    } smh_link_t;
endpackage : smh_pkg
